//--- core/gpm_pkg.sv
package gpm_pkg;

  // ------------------------------------------------------------------
  // Action codes
  // ------------------------------------------------------------------
  localparam logic [1:0] UNB_ACT_NONE     = 2'h0;
  localparam logic [1:0] UNB_ACT_SHUTDOWN = 2'h1;
  localparam logic [1:0] UNB_ACT_LOADDUMP = 2'h2;
  localparam logic [1:0] UNB_ACT_WARNING  = 2'h3;
  localparam logic       OC_ACT_SHUTDOWN  = 1'h0;
  localparam logic       OC_ACT_LOADDUMP  = 1'h1;

  // ------------------------------------------------------------------
  // Voltage set selection
  // ------------------------------------------------------------------
  localparam logic [1:0] VSET_PRIMARY   = 2'h0;
  localparam logic [1:0] VSET_SECONDARY = 2'h1;
  localparam logic [1:0] VSET_TERTIARY  = 2'h2;

  // ------------------------------------------------------------------
  // Topology codes
  // ------------------------------------------------------------------
  localparam logic [2:0] TOPO_2PH_L1L2   = 3'h0;
  localparam logic [2:0] TOPO_2PH_L1L3   = 3'h1;
  localparam logic [2:0] TOPO_3W2CT_L1L2 = 3'h2;
  localparam logic [2:0] TOPO_RESERVED   = 3'h3;
  localparam logic [2:0] TOPO_3W2CT_L1L3 = 3'h4;
  localparam logic [2:0] TOPO_4W_STAR    = 3'h5;
  localparam logic [2:0] TOPO_4W_DELTA   = 3'h6;
  localparam logic [2:0] TOPO_1PH        = 3'h7;
  localparam logic [2:0] TOPO_RESET      = TOPO_4W_STAR;

  // ------------------------------------------------------------------
  // Arithmetic and timing constants
  // ------------------------------------------------------------------
  localparam logic [31:0] UNB_SCALE     = 32'h0000_03E8;
  localparam logic [7:0]  OC_TRIP_UNITS = 8'h40;
  localparam logic [15:0] SEC_PER_MIN   = 16'h003C;
  localparam logic [15:0] GAP_SAT       = 16'hFFFF;
  localparam logic [15:0] CNT_RESET     = 16'h0000;

endpackage

//--- core/gpm_monitor.sv
// What this block does
// - Flag current unbalance beyond limit in tenths of a percent; zero disables
// - Unbalance action code: none, shutdown, loaddump, warning
// - Reverse power warning above kW limit; zero disables
// - Reverse power loaddump above separate kW limit, only while the warning limit is nonzero
// - Reverse power fault only after timer persists
// - Overcurrent fault on load above limit; zero disables
// - Secondary/tertiary voltage set selects limit two/three
// - Overcurrent action: 0 shutdown, 1 loaddump
// - Time multiplier scales overcurrent reaction speed
// - Overload loaddump on load above kW limit
// - Overload fault only after overload timer persists
// - Load-shed relay off below low limit
// - Load-shed relay on above high limit
// - Minimum spacing between two load-add pulses
// - Load-add held off after load-subtract pulse
// - Mains waiting time before dropping genset contactor
// - Decode mains topology code, default five
// - Decode genset topology code, same encoding
// - Shutdown alarm stops the engine
`timescale 1ns/1ps
module gpm_monitor #(
  parameter int CUR_W = 16,
  parameter int KW_W  = 16
) (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   sec_tick,
  input  wire logic [CUR_W-1:0]       cur_l1,
  input  wire logic [CUR_W-1:0]       cur_l2,
  input  wire logic [CUR_W-1:0]       cur_l3,
  input  wire logic signed [KW_W:0]   power_kw,
  input  wire logic                   gen_on_load,
  input  wire logic                   mains_ok,
  input  wire logic                   gen_contactor_req,
  input  wire logic                   load_add_req,
  input  wire logic                   load_sub_req,
  input  wire logic [9:0]             unb_limit,
  input  wire logic [1:0]             unb_action,
  input  wire logic [KW_W-1:0]        rp_warn_kw,
  input  wire logic [KW_W-1:0]        rp_ldump_kw,
  input  wire logic [6:0]             rp_timer_s,
  input  wire logic [CUR_W-1:0]       oc_limit1,
  input  wire logic [CUR_W-1:0]       oc_limit2,
  input  wire logic [CUR_W-1:0]       oc_limit3,
  input  wire logic [1:0]             volt_set,
  input  wire logic                   oc_action,
  input  wire logic [6:0]             oc_time_mult,
  input  wire logic [KW_W-1:0]        ol_limit_kw,
  input  wire logic [6:0]             ol_timer_s,
  input  wire logic [KW_W-1:0]        shed_low_kw,
  input  wire logic [KW_W-1:0]        shed_high_kw,
  input  wire logic [7:0]             add_delay_s,
  input  wire logic [6:0]             sub_add_delay_min,
  input  wire logic [15:0]            mains_wait_s,
  input  wire logic                   mains_topo_wr,
  input  wire logic                   gen_topo_wr,
  input  wire logic [2:0]             topo_wdata,
  output logic                        unb_fault,
  output logic                        rp_warning,
  output logic                        rp_loaddump,
  output logic                        oc_fault,
  output logic                        ol_fault,
  output logic                        alarm_warning,
  output logic                        alarm_loaddump,
  output logic                        alarm_shutdown,
  output logic                        engine_stop,
  output logic                        shed_relay,
  output logic                        load_add_pulse,
  output logic                        load_sub_pulse,
  output logic                        gen_contactor,
  output logic [2:0]                  mains_topo,
  output logic [2:0]                  gen_topo,
  output logic [1:0]                  mains_phases,
  output logic [1:0]                  mains_cts,
  output logic [1:0]                  gen_phases,
  output logic [1:0]                  gen_cts
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Compares |3x - sum| * 1000 against limit * sum, i.e. deviation from
  // the mean in tenths of a percent, without any divider.
  function automatic logic unb_over(input logic [CUR_W-1:0] x, input logic [31:0] sum,
                                    input logic [9:0] lim);
    logic [31:0] x3;
    logic [31:0] dev;
    x3  = 32'(x) * 32'h0000_0003;
    dev = (x3 > sum) ? (x3 - sum) : (sum - x3);
    return (dev * gpm_pkg::UNB_SCALE) > (32'(lim) * sum);
  endfunction

  // Seconds persistence counter; clears whenever the condition drops.
  function automatic logic [15:0] persist(input logic cond, input logic tick,
                                          input logic [15:0] cnt, input logic [15:0] lim);
    if (!cond) begin
      return gpm_pkg::CNT_RESET;
    end
    return (tick && cnt < lim) ? cnt + 16'h0001 : cnt;
  endfunction

  // Saturating seconds counter since an event.
  function automatic logic [15:0] gap_inc(input logic tick, input logic [15:0] cnt);
    return (tick && cnt != gpm_pkg::GAP_SAT) ? cnt + 16'h0001 : cnt;
  endfunction

  function automatic logic [1:0] topo_phases(input logic [2:0] t);
    case (t)
      gpm_pkg::TOPO_2PH_L1L2, gpm_pkg::TOPO_2PH_L1L3: return 2'h2;
      gpm_pkg::TOPO_1PH:                               return 2'h1;
      default:                                         return 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] topo_cts(input logic [2:0] t);
    case (t)
      gpm_pkg::TOPO_2PH_L1L2, gpm_pkg::TOPO_2PH_L1L3,
      gpm_pkg::TOPO_3W2CT_L1L2, gpm_pkg::TOPO_3W2CT_L1L3: return 2'h2;
      gpm_pkg::TOPO_1PH:                                    return 2'h1;
      default:                                              return 2'h3;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [15:0] rp_cnt_r;
  logic [15:0] ol_cnt_r;
  logic [15:0] mains_cnt_r;
  logic [15:0] add_gap_r;
  logic [15:0] sub_gap_r;
  logic [7:0]  oc_acc_r;
  logic        shed_r;

  // ------------------------------------------------------------------
  // Current unbalance
  // ------------------------------------------------------------------
  wire [31:0] cur_sum = 32'(cur_l1) + 32'(cur_l2) + 32'(cur_l3);
  wire unb_det = (unb_limit != 10'h000) && (cur_sum != 32'h0) &&
                 (unb_over(cur_l1, cur_sum, unb_limit) || unb_over(cur_l2, cur_sum, unb_limit) ||
                  unb_over(cur_l3, cur_sum, unb_limit));
  wire unb_sd   = unb_det && (unb_action == gpm_pkg::UNB_ACT_SHUTDOWN);
  wire unb_ld   = unb_det && (unb_action == gpm_pkg::UNB_ACT_LOADDUMP);
  wire unb_wn   = unb_det && (unb_action == gpm_pkg::UNB_ACT_WARNING);

  // ------------------------------------------------------------------
  // Reverse power
  // ------------------------------------------------------------------
  wire              pwr_neg = power_kw < 0;
  wire [KW_W:0]     rev_mag = pwr_neg ? (KW_W+1)'(-power_kw) : '0;
  wire              rp_en   = rp_warn_kw != '0;
  wire rp_w_over = rp_en && pwr_neg && (rev_mag > {1'b0, rp_warn_kw});
  wire rp_l_over = rp_en && pwr_neg && (rp_ldump_kw != '0) && (rev_mag > {1'b0, rp_ldump_kw});
  wire [15:0] rp_cnt_nxt = persist(rp_w_over || rp_l_over, sec_tick, rp_cnt_r, 16'(rp_timer_s));
  wire rp_done = rp_cnt_r >= 16'(rp_timer_s);

  // ------------------------------------------------------------------
  // Overcurrent
  // ------------------------------------------------------------------
  wire [CUR_W-1:0] oc_lim = (volt_set == gpm_pkg::VSET_SECONDARY) ? oc_limit2 :
                            (volt_set == gpm_pkg::VSET_TERTIARY)  ? oc_limit3 : oc_limit1;
  wire oc_over = gen_on_load && (oc_lim != '0) &&
                 ((cur_l1 > oc_lim) || (cur_l2 > oc_lim) || (cur_l3 > oc_lim));
  wire [8:0] oc_sum = {1'b0, oc_acc_r} + {2'b00, oc_time_mult};
  // Accumulates the multiplier each second; a larger multiplier trips sooner
  wire [7:0] oc_acc_nxt = !oc_over ? 8'h00 :
                          (sec_tick && oc_acc_r < gpm_pkg::OC_TRIP_UNITS) ?
                          ((oc_sum > {1'b0, gpm_pkg::OC_TRIP_UNITS}) ? gpm_pkg::OC_TRIP_UNITS : oc_sum[7:0]) :
                          oc_acc_r;
  wire oc_det = oc_over && (oc_acc_r >= gpm_pkg::OC_TRIP_UNITS);

  // ------------------------------------------------------------------
  // Overload
  // ------------------------------------------------------------------
  wire ol_over = gen_on_load && (ol_limit_kw != '0) && !pwr_neg &&
                 (power_kw > $signed({1'b0, ol_limit_kw}));
  wire [15:0] ol_cnt_nxt = persist(ol_over, sec_tick, ol_cnt_r, 16'(ol_timer_s));
  wire ol_det = ol_over && (ol_cnt_r >= 16'(ol_timer_s));

  // ------------------------------------------------------------------
  // Alarm collection
  // ------------------------------------------------------------------
  wire rp_w_det = rp_w_over && rp_done;
  wire rp_l_det = rp_l_over && rp_done;
  wire sd_nxt = unb_sd || (oc_det && oc_action == gpm_pkg::OC_ACT_SHUTDOWN);
  wire ld_nxt = unb_ld || (oc_det && oc_action == gpm_pkg::OC_ACT_LOADDUMP) || ol_det || rp_l_det;
  wire wn_nxt = unb_wn || rp_w_det;

  // ------------------------------------------------------------------
  // Load shedding
  // ------------------------------------------------------------------
  // High test wins if limits are misordered, so the relay never chatters
  wire shed_nxt = (power_kw > $signed({1'b0, shed_high_kw})) ? 1'b1 :
                  (power_kw < $signed({1'b0, shed_low_kw}))  ? 1'b0 :
                  shed_r;
  wire [15:0] sub_need = 16'(sub_add_delay_min) * gpm_pkg::SEC_PER_MIN;
  wire add_ok   = (add_gap_r >= 16'(add_delay_s)) && (sub_gap_r >= sub_need);
  // Subtract has priority: a simultaneous add request waits
  wire sub_go   = load_sub_req;
  wire add_go   = load_add_req && add_ok && !sub_go;
  wire [15:0] add_gap_nxt = add_go ? 16'h0000 : gap_inc(sec_tick, add_gap_r);
  wire [15:0] sub_gap_nxt = sub_go ? 16'h0000 : gap_inc(sec_tick, sub_gap_r);

  // ------------------------------------------------------------------
  // Mains return
  // ------------------------------------------------------------------
  wire [15:0] mains_cnt_nxt = persist(mains_ok, sec_tick, mains_cnt_r, mains_wait_s);
  wire mains_back   = mains_ok && (mains_cnt_r >= mains_wait_s);
  wire gen_con_nxt  = gen_contactor_req && !mains_back;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rp_cnt_r    <= gpm_pkg::CNT_RESET;
      ol_cnt_r    <= gpm_pkg::CNT_RESET;
      mains_cnt_r <= gpm_pkg::CNT_RESET;
      oc_acc_r    <= 8'h00;
      add_gap_r   <= gpm_pkg::GAP_SAT;
      sub_gap_r   <= gpm_pkg::GAP_SAT;
      shed_r      <= 1'b0;
    end else begin
      rp_cnt_r    <= rp_cnt_nxt;
      ol_cnt_r    <= ol_cnt_nxt;
      mains_cnt_r <= mains_cnt_nxt;
      oc_acc_r    <= oc_acc_nxt;
      add_gap_r   <= add_gap_nxt;
      sub_gap_r   <= sub_gap_nxt;
      shed_r      <= shed_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      unb_fault      <= 1'b0;
      rp_warning     <= 1'b0;
      rp_loaddump    <= 1'b0;
      oc_fault       <= 1'b0;
      ol_fault       <= 1'b0;
      alarm_warning  <= 1'b0;
      alarm_loaddump <= 1'b0;
      alarm_shutdown <= 1'b0;
      engine_stop    <= 1'b0;
      load_add_pulse <= 1'b0;
      load_sub_pulse <= 1'b0;
      gen_contactor  <= 1'b0;
    end else begin
      unb_fault      <= unb_det;
      rp_warning     <= rp_w_det;
      rp_loaddump    <= rp_l_det;
      oc_fault       <= oc_det;
      ol_fault       <= ol_det;
      alarm_warning  <= wn_nxt;
      alarm_loaddump <= ld_nxt;
      alarm_shutdown <= sd_nxt;
      engine_stop    <= sd_nxt;
      load_add_pulse <= add_go;
      load_sub_pulse <= sub_go;
      gen_contactor  <= gen_con_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Topology
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mains_topo <= gpm_pkg::TOPO_RESET;
      gen_topo   <= gpm_pkg::TOPO_RESET;
    end else begin
      if (mains_topo_wr && topo_wdata != gpm_pkg::TOPO_RESERVED) begin
        mains_topo <= topo_wdata;
      end
      if (gen_topo_wr && topo_wdata != gpm_pkg::TOPO_RESERVED) begin
        gen_topo <= topo_wdata;
      end
    end
  end

  assign shed_relay   = shed_r;
  assign mains_phases = topo_phases(mains_topo);
  assign mains_cts    = topo_cts(mains_topo);
  assign gen_phases   = topo_phases(gen_topo);
  assign gen_cts      = topo_cts(gen_topo);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_stop_follows_shutdown;
    engine_stop == alarm_shutdown;
  endproperty
  a_stop_follows_shutdown: assert property (p_stop_follows_shutdown) else $error("engine stop differs");

  property p_topo_never_reserved;
    mains_topo != gpm_pkg::TOPO_RESERVED && gen_topo != gpm_pkg::TOPO_RESERVED;
  endproperty
  a_topo_never_reserved: assert property (p_topo_never_reserved) else $error("reserved topology");

  property p_shed_on;
    (power_kw > $signed({1'b0, shed_high_kw})) |=> shed_relay;
  endproperty
  a_shed_on: assert property (p_shed_on) else $error("shed relay not on");

  property p_shed_off;
    (power_kw < $signed({1'b0, shed_low_kw}) && power_kw <= $signed({1'b0, shed_high_kw})) |=> !shed_relay;
  endproperty
  a_shed_off: assert property (p_shed_off) else $error("shed relay not off");

  property p_ol_disabled;
    (ol_limit_kw == '0) |=> !ol_fault;
  endproperty
  a_ol_disabled: assert property (p_ol_disabled) else $error("overload while disabled");

  property p_oc_disabled;
    (oc_lim == '0 || !gen_on_load) |=> !oc_fault;
  endproperty
  a_oc_disabled: assert property (p_oc_disabled) else $error("overcurrent while disabled");

  property p_rp_restart;
    !(rp_w_over || rp_l_over) |=> (rp_cnt_r == 16'h0000) && !rp_warning;
  endproperty
  a_rp_restart: assert property (p_rp_restart) else $error("reverse timer kept");

  property p_add_spacing;
    load_add_pulse && add_delay_s != 8'h00 |=> !load_add_pulse;
  endproperty
  a_add_spacing: assert property (p_add_spacing) else $error("load add back to back");

  property p_add_after_sub;
    load_sub_pulse && sub_add_delay_min != 7'h00 |=> !load_add_pulse;
  endproperty
  a_add_after_sub: assert property (p_add_after_sub) else $error("load add too soon");

  property p_unb_warn;
    unb_det && unb_action == gpm_pkg::UNB_ACT_WARNING |=> alarm_warning && !engine_stop;
  endproperty
  a_unb_warn: assert property (p_unb_warn) else $error("unbalance warning wrong");

  property p_mains_drop;
    $rose(mains_back) && gen_contactor_req |=> !gen_contactor;
  endproperty
  a_mains_drop: assert property (p_mains_drop) else $error("contactor held after wait");

  c_shutdown:  cover property ($rose(engine_stop));
  c_rp_warn:   cover property ($rose(rp_warning));
  c_add_pulse: cover property (load_add_pulse);
  c_shed:      cover property ($fell(shed_relay));

endmodule

//--- verification/gpm_plant_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// Genset, contactor feedback and load relays
// --------------------------------------------------------------
module gpm_plant_model (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               gen_contactor,
  input  wire logic               load_add_pulse,
  input  wire logic               load_sub_pulse,
  input  wire logic [15:0]        set_cur1,
  input  wire logic [15:0]        set_cur2,
  input  wire logic [15:0]        set_cur3,
  input  wire logic signed [16:0] set_kw,
  output logic [15:0]             cur_l1,
  output logic [15:0]             cur_l2,
  output logic [15:0]             cur_l3,
  output logic signed [16:0]      power_kw,
  output logic                    gen_on_load,
  output logic [7:0]              add_steps,
  output logic [7:0]              sub_steps
);
  // Measurements lag the set point by one cycle, like a real sampler
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur_l1      <= 16'h0000;
      cur_l2      <= 16'h0000;
      cur_l3      <= 16'h0000;
      power_kw    <= 17'sh00000;
      gen_on_load <= 1'b0;
      add_steps   <= 8'h00;
      sub_steps   <= 8'h00;
    end else begin
      cur_l1      <= set_cur1;
      cur_l2      <= set_cur2;
      cur_l3      <= set_cur3;
      power_kw    <= set_kw;
      gen_on_load <= gen_contactor;
      add_steps   <= add_steps + {7'h00, load_add_pulse};
      sub_steps   <= sub_steps + {7'h00, load_sub_pulse};
    end
  end
endmodule

//--- verification/genset_protection_monitor_tb.sv
`timescale 1ns/1ps
module genset_protection_monitor_tb;
  logic               clock, rst_b, sec_tick, gen_on_load, mains_ok, gen_contactor_req;
  logic               load_add_req, load_sub_req, oc_action, mains_topo_wr, gen_topo_wr;
  logic [15:0]        cur_l1, cur_l2, cur_l3, cs1, cs2, cs3, oc_limit1, oc_limit2, oc_limit3;
  logic [15:0]        rp_warn_kw, rp_ldump_kw, ol_limit_kw, shed_low_kw, shed_high_kw, mains_wait_s;
  logic signed [16:0] power_kw, kw_set;
  logic [9:0]         unb_limit;
  logic [1:0]         unb_action, volt_set, mains_phases, mains_cts, gen_phases, gen_cts;
  logic [6:0]         rp_timer_s, oc_time_mult, ol_timer_s, sub_add_delay_min;
  logic [7:0]         add_delay_s, add_steps, sub_steps;
  logic [2:0]         topo_wdata, mains_topo, gen_topo;
  logic               unb_fault, rp_warning, rp_loaddump, oc_fault, ol_fault, alarm_warning;
  logic               alarm_loaddump, alarm_shutdown, engine_stop, shed_relay;
  logic               load_add_pulse, load_sub_pulse, gen_contactor;
  int                 bad_count, cmp_count;

  gpm_monitor i_gpm_monitor (.clock, .rst_b, .sec_tick, .cur_l1, .cur_l2, .cur_l3, .power_kw,
    .gen_on_load, .mains_ok, .gen_contactor_req, .load_add_req, .load_sub_req, .unb_limit,
    .unb_action, .rp_warn_kw, .rp_ldump_kw, .rp_timer_s, .oc_limit1, .oc_limit2, .oc_limit3,
    .volt_set, .oc_action, .oc_time_mult, .ol_limit_kw, .ol_timer_s, .shed_low_kw, .shed_high_kw,
    .add_delay_s, .sub_add_delay_min, .mains_wait_s, .mains_topo_wr, .gen_topo_wr, .topo_wdata,
    .unb_fault, .rp_warning, .rp_loaddump, .oc_fault, .ol_fault, .alarm_warning, .alarm_loaddump,
    .alarm_shutdown, .engine_stop, .shed_relay, .load_add_pulse, .load_sub_pulse, .gen_contactor,
    .mains_topo, .gen_topo, .mains_phases, .mains_cts, .gen_phases, .gen_cts);

  gpm_plant_model i_gpm_plant_model (.clock, .rst_b, .gen_contactor, .load_add_pulse,
    .load_sub_pulse, .set_cur1(cs1), .set_cur2(cs2), .set_cur3(cs3), .set_kw(kw_set), .cur_l1,
    .cur_l2, .cur_l3, .power_kw, .gen_on_load, .add_steps, .sub_steps);

  always #10 clock = ~clock;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Seconds tick is sparse so every count boundary is deterministic
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      sec_tick <= 1'b1;
      @(posedge clock);
      sec_tick <= 1'b0;
      repeat (2) @(posedge clock);
    end
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic plant(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                       input logic signed [16:0] p);
    @(posedge clock);
    cs1 <= a;
    cs2 <= b;
    cs3 <= c;
    kw_set <= p;
    cyc(4);
  endtask

  task automatic topo_wr(input logic m, input logic g, input logic [2:0] c);
    @(posedge clock);
    mains_topo_wr <= m;
    gen_topo_wr <= g;
    topo_wdata <= c;
    @(posedge clock);
    mains_topo_wr <= 1'b0;
    gen_topo_wr <= 1'b0;
    cyc(1);
  endtask

  task automatic req(input logic sub);
    @(posedge clock);
    if (sub) load_sub_req <= 1'b1;
    else load_add_req <= 1'b1;
    @(posedge clock);
    load_sub_req <= 1'b0;
    load_add_req <= 1'b0;
    cyc(3);
  endtask

  // Expected {phases, CTs} for a topology code
  function automatic logic [3:0] topo_exp(input logic [2:0] c);
    case (c)
      3'h0, 3'h1: topo_exp = 4'hA;
      3'h2, 3'h4: topo_exp = 4'hE;
      3'h5, 3'h6: topo_exp = 4'hF;
      3'h7:       topo_exp = 4'h5;
      default:    topo_exp = 4'h0;
    endcase
  endfunction

  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [2:0] k;
    clock = 1'b0;
    rst_b = 1'b0;
    sec_tick = 1'b0;
    mains_ok = 1'b0;
    gen_contactor_req = 1'b1;
    load_add_req = 1'b0;
    load_sub_req = 1'b0;
    oc_action = 1'b0;
    mains_topo_wr = 1'b0;
    gen_topo_wr = 1'b0;
    topo_wdata = 3'h0;
    cs1 = 16'h0064;
    cs2 = 16'h0064;
    cs3 = 16'h0064;
    kw_set = 17'sh00000;
    unb_limit = 10'h000;
    unb_action = 2'h0;
    volt_set = 2'h0;
    rp_warn_kw = 16'h0064;
    rp_ldump_kw = 16'h0096;
    rp_timer_s = 7'h02;
    oc_limit1 = 16'h01F4;
    oc_limit2 = 16'h02BC;
    oc_limit3 = 16'h0226;
    oc_time_mult = 7'h40;
    ol_limit_kw = 16'h012C;
    ol_timer_s = 7'h01;
    shed_low_kw = 16'h0064;
    shed_high_kw = 16'h012C;
    add_delay_s = 8'h02;
    sub_add_delay_min = 7'h00;
    mains_wait_s = 16'h0003;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    cyc(3);
    chk({mains_topo, gen_topo}, 16'h002D);
    chk({mains_phases, mains_cts, gen_phases, gen_cts}, 16'h00FF);
    chk({shed_relay, gen_contactor}, 16'h0001);
    for (int c = 0; c < 8; c++) begin
      k = (c == 3) ? 3'h2 : 3'(c);
      topo_wr(1'b1, 1'b1, 3'(c));
      chk({mains_topo, gen_topo}, {10'h000, k, k});
      chk({mains_phases, mains_cts, gen_phases, gen_cts}, {8'h00, topo_exp(k), topo_exp(k)});
    end
    topo_wr(1'b1, 1'b0, 3'h5);
    chk({mains_topo, gen_topo}, 16'h002F);
    @(posedge clock);
    unb_limit <= 10'h064;
    plant(16'h0064, 16'h0064, 16'h0082, 17'sh00000);
    for (int a = 0; a < 4; a++) begin
      @(posedge clock);
      unb_action <= 2'(a);
      cyc(3);
      chk(unb_fault, 1'b1);
      chk({alarm_shutdown, alarm_loaddump, alarm_warning, engine_stop}, {a == 1, a == 2, a == 3, a == 1});
    end
    @(posedge clock);
    unb_limit <= 10'h000;
    cyc(3);
    chk(unb_fault, 1'b0);
    plant(16'h0064, 16'h0064, 16'h0064, -17'sh000C8);
    chk(rp_warning, 1'b0);
    tick(1);
    chk(rp_warning, 1'b0);
    tick(1);
    chk({rp_warning, rp_loaddump, alarm_loaddump}, 16'h0007);
    plant(16'h0064, 16'h0064, 16'h0064, 17'sh00000);
    chk(rp_warning, 1'b0);
    plant(16'h0064, 16'h0064, 16'h0064, -17'sh00078);
    tick(1);
    chk(rp_warning, 1'b0);
    tick(1);
    chk({rp_warning, rp_loaddump}, 16'h0002);
    @(posedge clock);
    rp_warn_kw <= 16'h0000;
    cyc(3);
    chk(rp_warning, 1'b0);
    plant(16'h0258, 16'h0258, 16'h0258, 17'sh00000);
    chk(oc_fault, 1'b0);
    tick(1);
    chk({oc_fault, alarm_shutdown, engine_stop}, 16'h0007);
    @(posedge clock);
    volt_set <= 2'h1;
    cyc(3);
    chk(oc_fault, 1'b0);
    @(posedge clock);
    volt_set <= 2'h2;
    oc_time_mult <= 7'h10;
    oc_action <= 1'b1;
    tick(3);
    chk(oc_fault, 1'b0);
    tick(1);
    chk({oc_fault, alarm_loaddump, alarm_shutdown}, 16'h0006);
    @(posedge clock);
    oc_limit3 <= 16'h0000;
    cyc(3);
    chk(oc_fault, 1'b0);
    plant(16'h0064, 16'h0064, 16'h0064, 17'sh00190);
    chk({shed_relay, ol_fault}, 16'h0002);
    tick(1);
    chk({ol_fault, alarm_loaddump}, 16'h0003);
    @(posedge clock);
    ol_limit_kw <= 16'h0000;
    cyc(3);
    chk(ol_fault, 1'b0);
    @(posedge clock);
    ol_limit_kw <= 16'h012C;
    tick(1);
    chk(ol_fault, 1'b1);
    @(posedge clock);
    gen_contactor_req <= 1'b0;
    cyc(4);
    chk({ol_fault, gen_contactor}, 16'h0000);
    @(posedge clock);
    gen_contactor_req <= 1'b1;
    plant(16'h0064, 16'h0064, 16'h0064, 17'sh000C8);
    chk(shed_relay, 1'b1);
    plant(16'h0064, 16'h0064, 16'h0064, 17'sh00032);
    chk(shed_relay, 1'b0);
    plant(16'h0064, 16'h0064, 16'h0064, 17'sh000C8);
    chk(shed_relay, 1'b0);
    req(1'b0);
    chk(add_steps, 8'h01);
    req(1'b0);
    chk(add_steps, 8'h01);
    tick(1);
    req(1'b0);
    chk(add_steps, 8'h01);
    tick(1);
    req(1'b0);
    chk(add_steps, 8'h02);
    @(posedge clock);
    sub_add_delay_min <= 7'h01;
    req(1'b1);
    chk(sub_steps, 8'h01);
    tick(2);
    req(1'b0);
    chk(add_steps, 8'h02);
    tick(58);
    req(1'b0);
    chk(add_steps, 8'h03);
    @(posedge clock);
    mains_ok <= 1'b1;
    tick(2);
    chk(gen_contactor, 1'b1);
    tick(1);
    chk(gen_contactor, 1'b0);
    @(posedge clock);
    mains_ok <= 1'b0;
    cyc(3);
    chk(gen_contactor, 1'b1);
    complete_run();
  end
endmodule
